// ==== bench/dwc_host_model.sv ====
module dwc_host_model (
   input wire logic clk,
   input wire logic dmarq,
   input wire logic slow,
   input wire logic [15:0] base,
   output logic dmack_pin,
   output logic dwr_strobe_pin,
   output logic [15:0] dd_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ph = 4'h0;
   logic [15:0] k = 16'h0000;
   // ==========================================
   // host channel
   initial begin
      dmack_pin = 1'b0;
      dwr_strobe_pin = 1'b0;
      dd_pin = 16'h0000;
   end
   // armed before any opcode; the request is only looked at between words
   always @(posedge clk) begin
      if (ph == 4'h0 && dmarq !== 1'b1) begin
         dmack_pin <= 1'b0;
         dd_pin <= ~dd_pin; // a released bus never holds its last word
         k <= 16'h0000;
      end else begin
         if (ph == 4'h0) begin
            dmack_pin <= 1'b1;
            dd_pin <= base + k;
         end
         dwr_strobe_pin <= (ph == 4'h1 || ph == 4'h2);
         if (ph == 4'h3) k <= k + 16'h0001;
         ph <= (ph == (slow ? 4'hB : 4'h5)) ? 4'h0 : ph + 4'h1; // slow host stretches each word
      end
   end
endmodule : dwc_host_model

// ==== bench/ext_dma_write_command_decoder_tb_top.sv ====
module ext_dma_write_command_decoder_tb_top
   import dwc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, irq, irq_q, dmarq, dmack_pin, dwr_strobe_pin, media_word_valid, cmd_high_priority;
   logic [15:0] dd_pin, media_word;
   logic [15:0] base = 16'h0000;
   logic sec_err = 1'b0;
   logic commit = 1'b0;
   logic crc = 1'b0;
   logic slow = 1'b0;
   logic [4:0] cmd_tag, tag;
   logic [1:0] cmd_priority;
   logic [7:0] op;
   logic [47:0] lba, fl;
   int error_cnt = 0, n_compared = 0, idx = 0, rises = 0, cyc = 0;
   always #20 clk = ~clk;
   dwc_write_decoder u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .dmarq(dmarq), .dmack_pin(dmack_pin),
      .dwr_strobe_pin(dwr_strobe_pin), .dd_pin(dd_pin), .media_word(media_word),
      .media_word_valid(media_word_valid), .media_sector_error(sec_err), .media_commit_done(commit),
      .link_crc_error(crc), .cmd_tag(cmd_tag), .cmd_priority(cmd_priority),
      .cmd_high_priority(cmd_high_priority));
   dwc_host_model u_host (.clk(clk), .dmarq(dmarq), .slow(slow), .base(base), .dmack_pin(dmack_pin),
      .dwr_strobe_pin(dwr_strobe_pin), .dd_pin(dd_pin));
   // ==========================================
   // helpers
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // one bus cycle; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) error_cnt++;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wpair(input logic [5:0] a, input logic [15:0] v);
      bus(1'b1, a, v[15:8]); // previous byte goes first
      bus(1'b1, a, v[7:0]);
   endtask : wpair
   task automatic cmd(input logic [7:0] c, input logic [15:0] ft, input logic [15:0] sc, input logic [7:0] drv);
      wpair(OFS_FEATURE, ft);
      wpair(OFS_SECCNT, sc);
      wpair(OFS_ADDR0, {lba[31:24], lba[7:0]});
      wpair(OFS_ADDR1, {lba[39:32], lba[15:8]});
      wpair(OFS_ADDR2, {lba[47:40], lba[23:16]});
      bus(1'b1, OFS_DRVSEL, drv);
      base <= 16'($urandom);
      idx = 0;
      rises = 0;
      bus(1'b1, OFS_OPCODE, c);
   endtask : cmd
   // ending status, word count, single interrupt and its read-clear
   task automatic fin(input logic [1:0] ist, input logic [7:0] ev, input int words);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      if (n == 9000) error_cnt++;
      bus(1'b0, OFS_OPCODE, 8'h00);
      check(q & 32'hF5, {24'h0, 8'h50 | 8'(ev != 8'h00)});
      bus(1'b0, OFS_ERROR, 8'h00);
      check(q, {24'h0, ev});
      if (words >= 0) check(32'(idx), 32'(words));
      check(32'(rises), 1);
      bus(1'b0, OFS_IRQ_STAT, 8'h00);
      check(q, {30'h0, ist});
      @(negedge clk);
      check({31'h0, irq}, 0);
   endtask : fin
   // ==========================================
   // monitor and hang guard
   always @(negedge clk) begin
      cyc++;
      if (irq === 1'b1 && irq_q !== 1'b1) rises++;
      irq_q = irq;
      if (media_word_valid === 1'b1) begin
         check({16'h0, media_word}, {16'h0, base + 16'(idx)});
         idx++;
      end
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // ==========================================
   // scenarios
   initial begin
      void'($urandom(15));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      bus(1'b0, 6'h2C, 8'h00);
      check(q, 0); // unmapped reads zero
      bus(1'b1, OFS_IRQ_MASK, 8'h03);
      bus(1'b0, OFS_IRQ_MASK, 8'h00);
      check(q, 3);
      lba = {16'($urandom), 32'($urandom)};
      cmd(OP_EXT_DMA_WRITE, 16'h0000, 16'h0001, 8'h40);
      fin(2'h1, 8'h00, 256);
      // failure in the second sector, slow host
      slow <= 1'b1;
      cmd(OP_EXT_DMA_WRITE, 16'h0000, 16'h0002, 8'h40);
      while (idx < 266) @(posedge clk);
      sec_err <= 1'b1;
      @(posedge clk);
      sec_err <= 1'b0;
      fin(2'h3, 8'h04, -1);
      check(32'(idx < 300), 1);
      for (int i = 0; i < 6; i++) begin
         if (i % 3 == 0) bus(1'b1, OFS_CTRL, 8'(i / 3));
         bus(1'b0, 6'(OFS_ADDR0 + 6'(4 * (i % 3))), 8'h00);
         fl[8 * i +: 8] = q[7:0];
      end
      check({8'h0, fl[47:24]}, {8'h0, 24'((lba + 48'h1) >> 24)});
      check({8'h0, fl[23:0]}, {8'h0, 24'(lba + 48'h1)});
      // unknown opcode while the interrupt is masked
      op = 8'($urandom);
      if (op == OP_EXT_DMA_WRITE || op == OP_QUEUED_WRITE) op = 8'hFF;
      bus(1'b1, OFS_IRQ_MASK, 8'h00);
      cmd(op, 16'h0001, 16'h0001, 8'h40);
      repeat (20) @(posedge clk);
      check({30'h0, irq, dmarq}, 0);
      bus(1'b1, OFS_IRQ_MASK, 8'h03);
      fin(2'h3, 8'h04, 0);
      // refused priority code, then an end address past the last block
      cmd(OP_QUEUED_WRITE, 16'h0001, 16'hC000, 8'h40);
      fin(2'h3, 8'h04, 0);
      lba = 48'hFFFFFFFFFFFF;
      cmd(OP_EXT_DMA_WRITE, 16'h0000, 16'h0002, 8'h40);
      fin(2'h3, 8'h10, 0);
      // queued writes at every priority, forced commit on the last
      for (int p = 0; p < 3; p++) begin
         tag = 5'($urandom);
         slow <= (p == 1);
         cmd(OP_QUEUED_WRITE, 16'h0001, {2'(p), 6'h00, tag, 3'h0}, p == 2 ? 8'hC0 : 8'h40);
         repeat (3) @(negedge clk);
         check({cmd_high_priority, cmd_priority, cmd_tag}, {p == 2, 2'(p), tag});
         if (p == 0) begin
            // link checksum fault mid-transfer, reported only at the end
            @(posedge clk);
            crc <= 1'b1;
            @(posedge clk);
            crc <= 1'b0;
         end
         if (p == 2) begin
            while (idx < 256) @(posedge clk);
            repeat (30) @(posedge clk);
            check({31'h0, irq}, 0);
            commit <= 1'b1;
            @(posedge clk);
            commit <= 1'b0;
         end
         fin(p == 0 ? 2'h3 : 2'h1, p == 0 ? 8'h80 : 8'h00, 256);
      end
      wrap_up();
   end
endmodule : ext_dma_write_command_decoder_tb_top

// ==== logic/dwc_pkg.sv ====
package dwc_pkg;
   // ==========================================
   // command opcodes
   localparam logic [7:0] OP_EXT_DMA_WRITE = 8'h35;
   localparam logic [7:0] OP_QUEUED_WRITE = 8'h61;
   // ==========================================
   // register byte offsets
   localparam logic [5:0] OFS_FEATURE = 6'h00;
   localparam logic [5:0] OFS_SECCNT = 6'h04;
   localparam logic [5:0] OFS_ADDR0 = 6'h08;
   localparam logic [5:0] OFS_ADDR1 = 6'h0C;
   localparam logic [5:0] OFS_ADDR2 = 6'h10;
   localparam logic [5:0] OFS_DRVSEL = 6'h14;
   localparam logic [5:0] OFS_OPCODE = 6'h18;
   localparam logic [5:0] OFS_ERROR = 6'h1C;
   localparam logic [5:0] OFS_CTRL = 6'h20;
   localparam logic [5:0] OFS_IRQ_STAT = 6'h24;
   localparam logic [5:0] OFS_IRQ_MASK = 6'h28;
   // pair index inside the pair array
   localparam int PAIR_FT = 0;
   localparam int PAIR_SC = 1;
   localparam int PAIR_A0 = 2;
   localparam int PAIR_A1 = 3;
   localparam int PAIR_A2 = 4;
   localparam int PAIRS = 5;
   // ==========================================
   // field positions
   localparam int ERR_CRC_BIT = 7;
   localparam int ERR_IDN_BIT = 4;
   localparam int ERR_ABT_BIT = 2;
   localparam int FUA_BIT = 7;
   localparam int CTRL_UPPER_BIT = 0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_FAIL_BIT = 1;
   localparam logic [1:0] REQUEST_PRIORITY_NORMAL = 2'h0;
   localparam logic [1:0] REQUEST_PRIORITY_ISOCH = 2'h1;
   localparam logic [1:0] REQUEST_PRIORITY_HIGH = 2'h2;
   // ==========================================
   // sizes and reset values
   localparam int WORDS_PER_SECTOR = 256;
   localparam logic [16:0] FULL_COUNT = 17'h10000;
   localparam logic [7:0] TASKFILE_RESET = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_XFER = 3'b010,
      ST_COMMIT = 3'b100
   } dwc_state_type;
endpackage : dwc_pkg

// ==== logic/dwc_sync.sv ====
module dwc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   // ==========================================
   // two stages; the first is read by the second only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : dwc_sync

// ==== logic/dwc_write_decoder.sv ====
// Operation
// R1 - opcode 35h runs an extended DMA write, host to device, then media.
// R2 - sector payload moves as 16-bit words, one per transfer.
// R3 - host arms its slave DMA channel before writing the opcode.
// R4 - each word moves only while the device holds its DMA request.
// R5 - exactly one interrupt per command, once transfer ends and status readable.
// R6 - uncorrectable error stops the write at the failing sector.
// R7 - count is previous:current sector count; zero means 65,536 sectors.
// R8 - 48-bit address from current bytes (low) and previous bytes (high).
// R9 - after error, address registers hold failing address; upper select picks high bytes.
// R10 - error register: only CRC, ID-not-found, aborted bits meaningful; others zero.
// R11 - at completion busy, fault, corrected clear; ready, seek, error valid.
// R12 - opcode 61h runs queued first-party DMA write, stopping at failing sector.
// R13 - queued write count comes from feature pair, previous high byte.
// R14 - host puts a unique tag in sector count current bits 7 to 3.
// R15 - queued priority in sector count previous bits 7:6; high is favoured.
// R16 - forced media commit bit delays completion until data reaches media.
//
// Chosen here: the address map and register access over Avalon-MM.
module dwc_write_decoder
   import dwc_pkg::*;
#(
   parameter logic [47:0] MAX_LBA = 48'hFFFFFFFFFFFF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   output logic dmarq,
   input wire logic dmack_pin,
   input wire logic dwr_strobe_pin,
   input wire logic [15:0] dd_pin,
   output logic [15:0] media_word,
   output logic media_word_valid,
   input wire logic media_sector_error,
   input wire logic media_commit_done,
   input wire logic link_crc_error,
   output logic [4:0] cmd_tag,
   output logic [1:0] cmd_priority,
   output logic cmd_high_priority
);
   import dwc_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   dwc_xfer_if xf ();

   dwc_xfer_engine #(
      .WORDS(WORDS_PER_SECTOR)
   ) u_engine (
      .clk(clk),
      .nrst(nrst),
      .xf(xf)
   );

   // ==========================================
   // pin synchronisation
   logic [17:0] pins_s;
   logic strobe_d_reg;
   logic word_pulse;
   dwc_sync #(
      .WIDTH(18)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .async_in({dmack_pin, dwr_strobe_pin, dd_pin}),
      .sync_out(pins_s)
   );

   // rising strobe with acknowledge while the request stands [R4] [R3]
   assign word_pulse = pins_s[16] && !strobe_d_reg && pins_s[17] && xf.dmarq;

   // ==========================================
   // state
   dwc_state_type state_reg, state_next;
   logic [7:0] cur_reg [PAIRS];
   logic [7:0] cur_next [PAIRS];
   logic [7:0] prev_reg [PAIRS];
   logic [7:0] prev_next [PAIRS];
   logic [7:0] drvsel_reg, drvsel_next;
   logic upper_reg, upper_next;
   logic [1:0] irq_stat_reg, irq_stat_next;
   logic [1:0] irq_mask_reg, irq_mask_next;
   logic crc_reg, crc_next;
   logic idn_reg, idn_next;
   logic abt_reg, abt_next;
   logic fua_reg, fua_next;
   logic start_reg, start_next;
   logic [16:0] count_reg, count_next;
   logic [47:0] lba_reg, lba_next;
   logic [4:0] tag_reg, tag_next;
   logic [1:0] request_priority_reg, request_priority_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [15:0] word_reg, word_next;
   logic wvalid_reg, wvalid_next;

   logic wr_acc, rd_acc, idle, is_ext, is_q, bad_cmd;
   logic [47:0] cmd_lba, fail_lba;
   logic [16:0] cmd_count;
   logic [48:0] end_lba;
   logic [7:0] status_byte, error_byte;
   logic complete;

   // ==========================================
   // command decode, combinational
   assign idle = (state_reg == ST_IDLE);
   assign wr_acc = avs_write && ack_reg;
   assign rd_acc = avs_read && ack_reg;
   assign is_ext = (avs_writedata[7:0] == OP_EXT_DMA_WRITE); // [R1]
   assign is_q = (avs_writedata[7:0] == OP_QUEUED_WRITE); // [R12]
   // priority code 11b is undefined, so it is refused [R15]
   assign bad_cmd = !(is_ext || is_q) || (is_q && prev_reg[PAIR_SC][7:6] == 2'h3);
   // low three bytes from current, high three from previous [R8]
   assign cmd_lba = {prev_reg[PAIR_A2], prev_reg[PAIR_A1], prev_reg[PAIR_A0],
                     cur_reg[PAIR_A2], cur_reg[PAIR_A1], cur_reg[PAIR_A0]};
   always_comb begin
      if (is_q) begin
         // queued count from the feature pair [R13]
         cmd_count = {1'b0, prev_reg[PAIR_FT], cur_reg[PAIR_FT]};
      end else begin
         cmd_count = {1'b0, prev_reg[PAIR_SC], cur_reg[PAIR_SC]}; // [R7]
      end
      if (cmd_count == 17'h00000) begin
         cmd_count = FULL_COUNT; // zero asks for the full 65,536 [R7]
      end
   end
   assign end_lba = {1'b0, cmd_lba} + {32'h00000000, cmd_count} - 49'h1;
   assign fail_lba = lba_reg + {31'h00000000, xf.sectors_done};
   // ready and seek-complete high, fault and corrected zero [R11]
   assign status_byte = {!idle, 1'b1, 1'b0, 1'b1, xf.dmarq, 1'b0, 1'b0,
                         crc_reg || idn_reg || abt_reg};
   // only crc, id-not-found and aborted may be set [R10]
   assign error_byte = {crc_reg, 2'h0, idn_reg, 1'b0, abt_reg, 2'h0};

   // ==========================================
   // next-state logic for bus, task file and sequencing
   always_comb begin
      state_next = state_reg;
      cur_next = cur_reg;
      prev_next = prev_reg;
      drvsel_next = drvsel_reg;
      upper_next = upper_reg;
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      crc_next = crc_reg;
      idn_next = idn_reg;
      abt_next = abt_reg;
      fua_next = fua_reg;
      start_next = 1'b0;
      count_next = count_reg;
      lba_next = lba_reg;
      tag_next = tag_reg;
      request_priority_next = request_priority_reg;
      ack_next = (avs_read || avs_write) && !ack_reg;
      rdata_next = rdata_reg;
      word_next = word_reg;
      wvalid_next = 1'b0;
      complete = 1'b0;
      // read data latched on the same edge that drops waitrequest
      if (avs_read && !ack_reg) begin
         rdata_next = 32'h00000000;
         case (avs_address)
            OFS_FEATURE, OFS_SECCNT, OFS_ADDR0, OFS_ADDR1, OFS_ADDR2: begin
               // upper select returns the previous byte [R9]
               rdata_next[7:0] = upper_reg ? prev_reg[avs_address[4:2]]
                                           : cur_reg[avs_address[4:2]];
            end
            OFS_DRVSEL: rdata_next[7:0] = drvsel_reg;
            OFS_OPCODE: rdata_next[7:0] = status_byte; // [R11]
            OFS_ERROR: rdata_next[7:0] = error_byte; // [R10]
            OFS_CTRL: rdata_next[CTRL_UPPER_BIT] = upper_reg;
            OFS_IRQ_STAT: rdata_next[1:0] = irq_stat_reg;
            OFS_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
            default: rdata_next = 32'h00000000;
         endcase
      end
      // reading the status clears it; a new event below still wins
      if (rd_acc && avs_address == OFS_IRQ_STAT) begin
         irq_stat_next = 2'h0;
      end
      if (wr_acc) begin
         case (avs_address)
            OFS_FEATURE, OFS_SECCNT, OFS_ADDR0, OFS_ADDR1, OFS_ADDR2: begin
               // task file is frozen while a command runs
               if (idle) begin
                  prev_next[avs_address[4:2]] = cur_reg[avs_address[4:2]];
                  cur_next[avs_address[4:2]] = avs_writedata[7:0];
               end
            end
            OFS_DRVSEL: begin
               if (idle) begin
                  drvsel_next = avs_writedata[7:0];
               end
            end
            OFS_CTRL: upper_next = avs_writedata[CTRL_UPPER_BIT];
            OFS_IRQ_MASK: irq_mask_next = avs_writedata[1:0];
            OFS_OPCODE: begin
               if (idle) begin
                  crc_next = 1'b0;
                  idn_next = 1'b0;
                  abt_next = 1'b0;
                  if (bad_cmd) begin
                     abt_next = 1'b1;
                     complete = 1'b1;
                  end else if (end_lba > {1'b0, MAX_LBA}) begin
                     idn_next = 1'b1;
                     complete = 1'b1;
                  end else begin
                     state_next = ST_XFER; // [R1] [R12]
                     start_next = 1'b1;
                     count_next = cmd_count;
                     lba_next = cmd_lba;
                     fua_next = is_q && drvsel_reg[FUA_BIT]; // [R16]
                     tag_next = is_q ? cur_reg[PAIR_SC][7:3] : 5'h00; // [R14]
                     request_priority_next = is_q ? prev_reg[PAIR_SC][7:6] : REQUEST_PRIORITY_NORMAL; // [R15]
                  end
               end
            end
            default: begin
            end
         endcase
      end
      // word capture toward media [R2]
      if (word_pulse) begin
         word_next = pins_s[15:0];
         wvalid_next = 1'b1;
      end
      if (link_crc_error && !idle) begin
         crc_next = 1'b1;
      end
      case (state_reg)
         ST_IDLE: begin
         end
         ST_XFER: begin
            if (xf.done) begin
               if (xf.failed) begin
                  // failing address back in the pairs [R9] [R6]
                  abt_next = 1'b1;
                  cur_next[PAIR_A0] = fail_lba[7:0];
                  cur_next[PAIR_A1] = fail_lba[15:8];
                  cur_next[PAIR_A2] = fail_lba[23:16];
                  prev_next[PAIR_A0] = fail_lba[31:24];
                  prev_next[PAIR_A1] = fail_lba[39:32];
                  prev_next[PAIR_A2] = fail_lba[47:40];
                  complete = 1'b1;
               end else if (fua_reg) begin
                  state_next = ST_COMMIT; // [R16]
               end else begin
                  complete = 1'b1;
               end
            end
         end
         ST_COMMIT: begin
            if (media_commit_done) begin
               complete = 1'b1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // one completion event per command [R5]
      if (complete) begin
         state_next = ST_IDLE;
         irq_stat_next[IRQ_DONE_BIT] = 1'b1;
         if (abt_next || idn_next || crc_next) begin
            irq_stat_next[IRQ_FAIL_BIT] = 1'b1;
         end
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         for (int i = 0; i < PAIRS; i++) begin
            cur_reg[i] <= TASKFILE_RESET;
            prev_reg[i] <= TASKFILE_RESET;
         end
         drvsel_reg <= TASKFILE_RESET;
         upper_reg <= 1'b0;
         irq_stat_reg <= IRQ_RESET;
         irq_mask_reg <= IRQ_RESET;
         crc_reg <= 1'b0;
         idn_reg <= 1'b0;
         abt_reg <= 1'b0;
         fua_reg <= 1'b0;
         start_reg <= 1'b0;
         count_reg <= '0;
         lba_reg <= '0;
         tag_reg <= '0;
         request_priority_reg <= REQUEST_PRIORITY_NORMAL;
         ack_reg <= 1'b0;
         rdata_reg <= '0;
         word_reg <= '0;
         wvalid_reg <= 1'b0;
         strobe_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         prev_reg <= prev_next;
         drvsel_reg <= drvsel_next;
         upper_reg <= upper_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         crc_reg <= crc_next;
         idn_reg <= idn_next;
         abt_reg <= abt_next;
         fua_reg <= fua_next;
         start_reg <= start_next;
         count_reg <= count_next;
         lba_reg <= lba_next;
         tag_reg <= tag_next;
         request_priority_reg <= request_priority_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         word_reg <= word_next;
         wvalid_reg <= wvalid_next;
         strobe_d_reg <= pins_s[16];
      end
   end

   // ==========================================
   // engine hookup and outputs
   assign xf.start = start_reg;
   assign xf.count = count_reg;
   assign xf.word_pulse = word_pulse;
   assign xf.sector_fail = media_sector_error;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign avs_readdata = rdata_reg;
   assign irq = |(irq_stat_reg & irq_mask_reg);
   assign dmarq = xf.dmarq; // [R4]
   assign media_word = word_reg;
   assign media_word_valid = wvalid_reg;
   assign cmd_tag = tag_reg;
   assign cmd_priority = request_priority_reg;
   // media scheduler gives this command precedence [R15]
   assign cmd_high_priority = (request_priority_reg == REQUEST_PRIORITY_HIGH);

   // ==========================================
   // checks
   a_ext_start: assert property ( // [R1]
      (wr_acc && avs_address == OFS_OPCODE && idle && is_ext && !bad_cmd
       && end_lba <= {1'b0, MAX_LBA}) |=> (state_reg == ST_XFER) ##1 xf.busy)
      else $error("extended write did not start");
   a_word_path: assert property ( // [R2]
      word_pulse |=> (media_word_valid && media_word == $past(pins_s[15:0])))
      else $error("data word not forwarded");
   a_word_gated: assert property ( // [R4]
      media_word_valid |-> $past(dmarq))
      else $error("word taken without request");
   a_single_irq: assert property ( // [R5]
      (state_reg != ST_IDLE && state_next == ST_IDLE) |=> irq_stat_reg[IRQ_DONE_BIT] && idle)
      else $error("completion not flagged");
   a_zero_count: assert property ( // [R7]
      (start_reg && count_reg[15:0] == 16'h0000) |-> count_reg == FULL_COUNT)
      else $error("zero count not full length");
   a_fail_addr: assert property ( // [R9]
      (state_reg == ST_XFER && xf.done && xf.failed) |=>
      (cur_reg[PAIR_A0] == $past(fail_lba[7:0]) && prev_reg[PAIR_A2] == $past(fail_lba[47:40])))
      else $error("failing address not reported");
   a_err_zero: assert property ( // [R10]
      (error_byte[6] == 1'b0 && error_byte[1:0] == 2'h0 && error_byte[5] == 1'b0))
      else $error("reserved error bits set");
   a_idle_status: assert property ( // [R11]
      idle |-> (status_byte[7:4] == 4'h5 && status_byte[2] == 1'b0))
      else $error("completion status wrong");
   a_fua_hold: assert property ( // [R16]
      (state_reg == ST_COMMIT && !media_commit_done) |=> state_reg == ST_COMMIT && !irq_stat_reg[IRQ_DONE_BIT] || $past(irq_stat_reg[IRQ_DONE_BIT]))
      else $error("completed before media commit");
endmodule : dwc_write_decoder

// ==== logic/dwc_xfer_engine.sv ====
module dwc_xfer_engine
   import dwc_pkg::*;
#(
   parameter int WORDS = WORDS_PER_SECTOR
) (
   input wire logic clk,
   input wire logic nrst,
   dwc_xfer_if.eng xf
);
   logic busy_reg, busy_next;
   logic done_reg, done_next;
   logic failed_reg, failed_next;
   logic [15:0] word_reg, word_next;
   logic [16:0] sec_reg, sec_next;
   logic [16:0] total_reg, total_next;

   // ==========================================
   // word and sector pacing
   always_comb begin
      busy_next = busy_reg;
      done_next = 1'b0;
      failed_next = failed_reg;
      word_next = word_reg;
      sec_next = sec_reg;
      total_next = total_reg;
      if (xf.start && !busy_reg) begin
         busy_next = 1'b1;
         failed_next = 1'b0;
         word_next = '0;
         sec_next = '0;
         total_next = xf.count;
      end else if (busy_reg) begin
         if (xf.sector_fail) begin
            // halt on the failing sector, later ones never requested [R6]
            busy_next = 1'b0;
            done_next = 1'b1;
            failed_next = 1'b1;
         end else if (xf.word_pulse) begin
            if (word_reg == 16'(WORDS - 1)) begin
               word_next = '0;
               sec_next = sec_reg + 17'h00001;
               if (sec_reg + 17'h00001 == total_reg) begin
                  busy_next = 1'b0;
                  done_next = 1'b1;
               end
            end else begin
               word_next = word_reg + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         failed_reg <= 1'b0;
         word_reg <= '0;
         sec_reg <= '0;
         total_reg <= '0;
      end else begin
         busy_reg <= busy_next;
         done_reg <= done_next;
         failed_reg <= failed_next;
         word_reg <= word_next;
         sec_reg <= sec_next;
         total_reg <= total_next;
      end
   end

   assign xf.busy = busy_reg;
   assign xf.done = done_reg;
   assign xf.failed = failed_reg;
   assign xf.sectors_done = sec_reg;
   assign xf.dmarq = busy_reg; // request only while words remain [R4]

   a_fail_halts: assert property (@(posedge clk) disable iff (!nrst) // [R6]
      (busy_reg && xf.sector_fail) |=> (!xf.dmarq && failed_reg && done_reg))
      else $error("request still active after sector failure");
endmodule : dwc_xfer_engine

// ==== logic/dwc_xfer_if.sv ====
interface dwc_xfer_if;
   logic start;
   logic [16:0] count;
   logic word_pulse;
   logic sector_fail;
   logic busy;
   logic done;
   logic failed;
   logic [16:0] sectors_done;
   logic dmarq;
   modport ctl (output start, count, word_pulse, sector_fail,
                input busy, done, failed, sectors_done, dmarq);
   modport eng (input start, count, word_pulse, sector_fail,
                output busy, done, failed, sectors_done, dmarq);
endinterface : dwc_xfer_if
